// File: rtc_power_pkg.sv
`default_nettype none
package rtc_power_pkg;
   // Register indices as printed; the byte address is four times the index.
   localparam logic [15:0] PMGT_INDEX = 16'h1930;
   localparam logic [15:0] WAKE_CTRL_INDEX = 16'h1934;
   localparam logic [15:0] STATUS_INDEX = 16'h1938;
   localparam logic [15:0] PMGT_ADDR = 16'(PMGT_INDEX * 4);
   localparam logic [15:0] WAKE_CTRL_ADDR = 16'(WAKE_CTRL_INDEX * 4);
   localparam logic [15:0] STATUS_ADDR = 16'(STATUS_INDEX * 4);

   // Power management register fields.
   localparam int PMGT_W = 5;
   localparam int CLKOUT_EN_BIT = 0;
   localparam int REG_PD_BIT = 1;
   localparam int BANDGAP_PD_BIT = 2;
   localparam int DIR_BIT = 3;
   localparam int OUT_LEVEL_BIT = 4;
   localparam logic [PMGT_W-1:0] PMGT_RESET = 5'h10;

   // Wake control register fields.
   localparam int WCTRL_W = 5;
   localparam int RATE_LSB = 0;
   localparam int RATE_W = 3;
   localparam int ALARM_WAKE_BIT = 3;
   localparam int PIN_SIGNAL_BIT = 4;
   localparam logic [WCTRL_W-1:0] WCTRL_RESET = 5'h00;

   // Status register width.
   localparam int STATUS_W = 7;

   // Timing: clock period and least wake pulse width.
   localparam int CLK_PERIOD_PS = 5000;
   localparam int WAKE_MIN_PS = 30500000;
   localparam int WAKE_MIN_CYCLES =
      (WAKE_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int WAKE_CNT_W = 13;
   // Number of RTC clock edges between a write and its visibility.
   localparam logic [1:0] SYNC_TICKS = 2'h2;

   typedef enum logic [1:0] {PWR_RAMP, PWR_ON, PWR_DOWN} pwr_state_t;
endpackage
`default_nettype wire

// File: rtc_power_wakeup_control.sv
// Summary of operation
// - CPU register writes are synchronised into the RTC clock domain.
// - A written value becomes visible two RTC clock cycles after the write.
// - With the RTC oscillator disabled every register write is ignored.
// - The RTC power-on reset is the only reset input of these flops.
// - Registers survive core power loss; the control register is cleared then.
// - Alarm, periodic event or high wake input raise the wake request.
// - Alarm or periodic event can be signalled low on the wake pin.
// - A power-down bit shuts the regulator and holds power-good low.
// - Supply at threshold raises power-good, releases system reset, drops isolation.
// - Output level bit: zero drives the pin low, one releases it.
// - Direction bit: zero is active-high input, one is open-drain output.
// - Bit 2 powers down regulators, analog reset and bandgap until wake.
// - Bit 1 powers down regulators and analog reset, bandgap stays on.
// - Bit 0 gates the RTC clock output.
// - Bits 15 to 5 read as zero and ignore writes.
// - Periodic rate selects millisecond, second, minute, hour or day.
`default_nettype none
module rtc_power_wakeup_control
   import rtc_power_pkg::*;
#(
   parameter int WAKE_MIN = WAKE_MIN_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rtc_clk,
   input wire logic osc_enable,
   input wire logic alarm_event,
   input wire logic [4:0] periodic_ticks,
   input wire logic supply_ok,
   input wire logic wake_pin_in,
   output logic wake_pin_out,
   output logic wake_pin_oe,
   output logic wake_request,
   output logic regulator_enable,
   output logic bandgap_enable,
   output logic analog_por_enable,
   output logic power_good,
   output logic rtc_isolate,
   output logic system_reset,
   output logic clock_out
);

   // Three-flop filter: a change counts once the last two stages agree.
   function automatic logic filt(input logic s2, input logic s3,
                                 input logic old);
      filt = (s2 == s3) ? s3 : old;
   endfunction

   logic [2:0] clk_sync;
   logic [2:0] pin_sync;
   logic clk_level;
   logic pin_level;
   logic [PMGT_W-1:0] pmgt;
   logic [WCTRL_W-1:0] wctrl;
   logic pend_valid;
   logic pend_is_pmgt;
   logic [WCTRL_W-1:0] pend_data;
   logic [1:0] pend_ticks;
   logic pin_event;
   logic [WAKE_CNT_W-1:0] wake_cnt;
   pwr_state_t state;
   pwr_state_t next_state;

   // Bus decode.
   wire sel_pmgt = (paddr == PMGT_ADDR);
   wire sel_wctrl = (paddr == WAKE_CTRL_ADDR);
   wire sel_status = (paddr == STATUS_ADDR);
   wire mapped = sel_pmgt | sel_wctrl | sel_status;
   wire setup_rd = psel & ~penable & ~pwrite;
   wire access = psel & penable & pready;
   wire wr_take = access & pwrite & (sel_pmgt | sel_wctrl);
   wire wr_accept = wr_take & osc_enable;

   // A write waits while an earlier one is still crossing, so none is lost.
   assign pready = ~(psel & pwrite & pend_valid);
   assign pslverr = psel & penable & ~mapped;

   // RTC clock edge seen in this domain.
   wire clk_next = filt(clk_sync[1], clk_sync[2], clk_level);
   wire rtc_tick = clk_next & ~clk_level;
   wire apply = pend_valid & rtc_tick & (pend_ticks == SYNC_TICKS - 2'h1);

   // Wake pin as input is active high only with direction set to input.
   // input direction
   wire pin_in_active = ~pmgt[DIR_BIT] & pin_level;
   wire [4:0] rate_onehot = 5'(1) << (wctrl[RATE_LSB +: RATE_W] - 3'h1);
   wire periodic = (wctrl[RATE_LSB +: RATE_W] != 3'h0) &&
                   (wctrl[RATE_LSB +: RATE_W] <= 3'h5) &&
                   ((periodic_ticks & rate_onehot) != 5'h00);
   wire alarm = alarm_event & wctrl[ALARM_WAKE_BIT];
   wire pd_request = pmgt[REG_PD_BIT] | pmgt[BANDGAP_PD_BIT];
   wire wake_qualified = (wake_cnt >= WAKE_CNT_W'(WAKE_MIN - 1)) &
                         pin_in_active;
   wire wake_up = wake_qualified | alarm_event;

   assign wake_request = pin_in_active | alarm | periodic;

   // Open-drain wake pin never drives high; the enable alone carries data.
   // level bit drives
   assign wake_pin_out = 1'b0;
   assign wake_pin_oe = pmgt[DIR_BIT] &
                        (~pmgt[OUT_LEVEL_BIT] |
                         (wctrl[PIN_SIGNAL_BIT] & pin_event));

   // Power sequencing outputs follow the state.
   // bandgap off
   assign bandgap_enable = ~((state == PWR_DOWN) & pmgt[BANDGAP_PD_BIT]);
   assign regulator_enable = (state != PWR_DOWN);
   assign analog_por_enable = (state != PWR_DOWN);

   // Synchroniser chains; only the second stage reads the first.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_sync <= 3'h0;
         pin_sync <= 3'h0;
         clk_level <= 1'b0;
         pin_level <= 1'b0;
      end else begin
         clk_sync <= {clk_sync[1:0], rtc_clk};
         pin_sync <= {pin_sync[1:0], wake_pin_in};
         clk_level <= clk_next;
         pin_level <= filt(pin_sync[1], pin_sync[2], pin_level);
      end
   end

   // Pending write: counts RTC edges until it may land.
   // two-edge latency
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_valid <= 1'b0;
         pend_is_pmgt <= 1'b0;
         pend_data <= 5'h00;
         pend_ticks <= 2'h0;
      end else if (wr_accept) begin
         pend_valid <= 1'b1;
         pend_is_pmgt <= sel_pmgt;
         pend_data <= pwdata[WCTRL_W-1:0];
         pend_ticks <= 2'h0;
      end else if (apply) begin
         pend_valid <= 1'b0;
      end else if (pend_valid & rtc_tick) begin
         pend_ticks <= pend_ticks + 2'h1;
      end
   end

   // Power management register; the sequencer clears the power-down bits
   // on wake so that the device does not drop straight back down.
   // POR only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pmgt <= PMGT_RESET;
      end else if (state == PWR_DOWN && next_state != PWR_DOWN) begin
         pmgt[REG_PD_BIT] <= 1'b0;
         pmgt[BANDGAP_PD_BIT] <= 1'b0;
      end else if (apply & pend_is_pmgt) begin
         pmgt <= pend_data[PMGT_W-1:0];
      end
   end

   // Wake control register is lost with core power, unlike the rest.
   // cleared on power loss
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wctrl <= WCTRL_RESET;
      end else if (!power_good) begin
         wctrl <= WCTRL_RESET;
      end else if (apply & ~pend_is_pmgt) begin
         wctrl <= pend_data;
      end
   end

   // Pin event flag: a new event wins over the clear by a control write.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_event <= 1'b0;
      end else if (alarm | periodic) begin
         pin_event <= 1'b1;
      end else if (apply & ~pend_is_pmgt) begin
         pin_event <= 1'b0;
      end
   end

   // Wake pulse width counter, saturating.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_cnt <= '0;
      end else if (!pin_in_active) begin
         wake_cnt <= '0;
      end else if (!wake_qualified) begin
         wake_cnt <= wake_cnt + WAKE_CNT_W'(1);
      end
   end

   // Power state: down on request, ramp on wake, on at supply threshold.
   always_comb begin
      next_state = state;
      case (state)
         PWR_RAMP: if (supply_ok) next_state = PWR_ON;
         PWR_ON: if (pd_request) next_state = PWR_DOWN;
         PWR_DOWN: if (wake_up) next_state = PWR_RAMP;
         default: next_state = PWR_RAMP;
      endcase
   end

   // Power-good, isolation and system reset are registered from the next state.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= PWR_RAMP;
         power_good <= 1'b0;
         rtc_isolate <= 1'b1;
         system_reset <= 1'b1;
      end else begin
         state <= next_state;
         power_good <= (next_state == PWR_ON);
         rtc_isolate <= (next_state != PWR_ON);
         system_reset <= (next_state != PWR_ON);
      end
   end

   // Clock output gated by its enable bit, from a flop to avoid glitches.
   // clock gate
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clock_out <= 1'b0;
      end else begin
         clock_out <= clk_level & pmgt[CLKOUT_EN_BIT];
      end
   end

   // Read data captured in the setup cycle; unused bits read as zero.
   wire [STATUS_W-1:0] status = {pin_event, pend_valid, osc_enable,
                                 pin_level, state == PWR_DOWN,
                                 rtc_isolate, power_good};
   wire [31:0] rd_mux = sel_pmgt ? {27'h0, pmgt} :
                        sel_wctrl ? {27'h0, wctrl} :
                        sel_status ? {25'h0, status} : 32'h0;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
      end else if (setup_rd) begin
         prdata <= rd_mux;
      end
   end

   // a write with the oscillator stopped leaves nothing pending.
   property p_osc_off_ignored;
      @(posedge pclk) disable iff (!presetn)
      (wr_take & ~osc_enable & ~pend_valid) |=> ~pend_valid;
   endproperty
   a_osc_off_ignored: assert property (p_osc_off_ignored)
      else $error("write accepted with oscillator off");

   // the register holds its old value until the write lands.
   property p_no_early_update;
      @(posedge pclk) disable iff (!presetn)
      (pend_valid & pend_is_pmgt & ~apply & state != PWR_DOWN)
         |=> pmgt == $past(pmgt);
   endproperty
   a_no_early_update: assert property (p_no_early_update)
      else $error("register changed before sync latency");

   property p_lands;
      @(posedge pclk) disable iff (!presetn)
      (apply & pend_is_pmgt & state == PWR_ON)
         |=> pmgt == $past(pend_data[PMGT_W-1:0]);
   endproperty
   a_lands: assert property (p_lands)
      else $error("synchronised write did not land");

   property p_reserved_zero;
      @(posedge pclk) disable iff (!presetn)
      (setup_rd & sel_pmgt) |=> prdata[31:PMGT_W] == 27'h0;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("reserved bits read non-zero");

   property p_power_down;
      @(posedge pclk) disable iff (!presetn)
      (state == PWR_ON & pd_request) |=> ~power_good ##0 rtc_isolate
         ##0 ~regulator_enable;
   endproperty
   a_power_down: assert property (p_power_down)
      else $error("power-down did not isolate");

   property p_power_up;
      @(posedge pclk) disable iff (!presetn)
      (state == PWR_RAMP & supply_ok) |=> power_good & ~rtc_isolate
         & ~system_reset;
   endproperty
   a_power_up: assert property (p_power_up)
      else $error("power-good not raised at threshold");

   property p_bandgap;
      @(posedge pclk) disable iff (!presetn)
      (state == PWR_DOWN) |-> (bandgap_enable == ~pmgt[BANDGAP_PD_BIT]);
   endproperty
   a_bandgap: assert property (p_bandgap)
      else $error("bandgap state wrong in power-down");

   property p_pin_dir;
      @(posedge pclk) disable iff (!presetn)
      wake_pin_oe |-> pmgt[DIR_BIT] & ~wake_pin_out;
   endproperty
   a_pin_dir: assert property (p_pin_dir)
      else $error("wake pin driven while input");

   property p_clock_gate;
      @(posedge pclk) disable iff (!presetn)
      clock_out |-> $past(pmgt[CLKOUT_EN_BIT]);
   endproperty
   a_clock_gate: assert property (p_clock_gate)
      else $error("clock output while disabled");

endmodule // rtc_power_wakeup_control
`default_nettype wire

// File: rtc_power_wakeup_control_bench.sv
`default_nettype none
module rtc_power_wakeup_control_bench;
   import rtc_power_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic rtc_clk, osc_enable, alarm_event, wake_cmd;
   logic [15:0] paddr;
   logic [31:0] pwdata, prdata, rd, w, prev;
   logic [4:0] periodic_ticks;
   logic [3:0] ramp;
   wire logic supply_ok, wake_pin_in, wake_pin_out, wake_pin_oe;
   wire logic wake_request, regulator_enable, bandgap_enable;
   wire logic analog_por_enable, power_good, rtc_isolate, system_reset;
   wire logic clock_out;
   int error_cnt, samples_checked, seed, n;

   rtc_power_wakeup_control #(.WAKE_MIN(8)) DUT (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rtc_clk(rtc_clk), .osc_enable(osc_enable),
      .alarm_event(alarm_event), .periodic_ticks(periodic_ticks),
      .supply_ok(supply_ok), .wake_pin_in(wake_pin_in),
      .wake_pin_out(wake_pin_out), .wake_pin_oe(wake_pin_oe),
      .wake_request(wake_request), .regulator_enable(regulator_enable),
      .bandgap_enable(bandgap_enable),
      .analog_por_enable(analog_por_enable), .power_good(power_good),
      .rtc_isolate(rtc_isolate), .system_reset(system_reset),
      .clock_out(clock_out));
   wake_partner partner (.pclk(pclk), .presetn(presetn),
      .regulator_enable(regulator_enable), .wake_pin_oe(wake_pin_oe),
      .wake_pin_out(wake_pin_out), .wake_cmd(wake_cmd), .ramp(ramp),
      .wake_pin_in(wake_pin_in), .supply_ok(supply_ok));

   // The slow clock is scaled up but stays well under a third of pclk.
   initial begin
      pclk = 0;
      forever #2.5 pclk = ~pclk;
   end
   initial begin
      rtc_clk = 0;
      #1.3;
      forever #41.5 rtc_clk = ~rtc_clk;
   end

   task automatic end_of_test;
      if (error_cnt == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen,
                      input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic tmo(input int k);
      if (k >= 4000) begin
         error_cnt++;
         end_of_test();
      end
   endtask

   // One APB transfer; the request holds until pready is seen high.
   task automatic apb(input logic wr, input logic [15:0] a,
                      input logic [31:0] d);
      int k;
      k = 0;
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      @(posedge pclk);
      while (pready !== 1'b1 && k < 4000) begin
         k++;
         @(posedge pclk);
      end
      tmo(k);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask

   // Polls the pending flag, since landing time follows the slow clock.
   task automatic settle;
      int k;
      k = 0;
      do begin
         apb(0, STATUS_ADDR, 0);
         k += 40;
      end while (rd[5] !== 1'b0 && k < 4000);
      tmo(k);
   endtask

   task automatic pg_wait(input logic lvl);
      int k;
      k = 0;
      while (power_good !== lvl && k < 4000) begin
         k++;
         @(posedge pclk);
      end
      tmo(k);
   endtask

   task automatic pulse_alarm;
      @(posedge pclk) alarm_event <= 1;
      repeat (2) @(posedge pclk);
      alarm_event <= 0;
   endtask

   function automatic logic [31:0] pm_exp(input logic [31:0] v);
      return {27'h0, v[4:0]};
   endfunction

   initial begin
      {psel, penable, pwrite, alarm_event, wake_cmd} = '0;
      {paddr, pwdata, periodic_ticks} = '0;
      osc_enable = 1;
      ramp = 4'h1;
      presetn = 0;
      seed = 32'h7c05;
      error_cnt = 0;
      samples_checked = 0;
      repeat (5) @(posedge pclk);
      presetn <= 1;
      pg_wait(1);
      apb(0, PMGT_ADDR, 0);
      chk("pmgt reset", rd, 32'h10);
      chk("pin oe reset", wake_pin_oe, 0);
      prev = 32'h10;
      // Corner words first, then random words with power-down bits clear.
      for (int i = 0; i < 10; i++) begin
         w = (i == 0) ? 32'hffff_fff9 : (i == 1) ? 32'h0 : $random(seed);
         w[2:1] = 2'b00;
         apb(1, PMGT_ADDR, w);
         apb(0, PMGT_ADDR, 0);
         chk("pmgt before sync", rd, prev);
         settle();
         apb(0, PMGT_ADDR, 0);
         chk("pmgt", rd, pm_exp(w));
         chk("pin oe", wake_pin_oe, w[3] & ~w[4]);
         prev = pm_exp(w);
      end
      apb(1, PMGT_ADDR, 32'h11);
      settle();
      n = 0;
      repeat (100) @(posedge pclk) n += int'(clock_out === 1'b1);
      chk("clock out on", n > 0, 1);
      osc_enable <= 0;
      apb(1, PMGT_ADDR, 32'h10);
      settle();
      apb(0, PMGT_ADDR, 0);
      chk("write with osc off", rd, 32'h11);
      osc_enable <= 1;
      apb(1, PMGT_ADDR, 32'h10);
      settle();
      n = 0;
      repeat (100) @(posedge pclk) n += int'(clock_out !== 1'b0);
      chk("clock out off", n, 0);
      apb(0, 16'h0100, 0);
      chk("unmapped error", err, 1);
      // Rates 6 and 7 are unused codes and must select no tick.
      for (int r = 0; r < 8; r++) begin
         apb(1, WAKE_CTRL_ADDR, r);
         settle();
         for (int b = 0; b < 5; b++) begin
            @(posedge pclk) periodic_ticks <= 5'(1 << b);
            @(negedge pclk);
            chk("tick wake", wake_request, b == r - 1);
         end
         @(posedge pclk) periodic_ticks <= 0;
      end
      apb(1, WAKE_CTRL_ADDR, 32'h8);
      settle();
      @(posedge pclk) alarm_event <= 1;
      @(negedge pclk);
      chk("alarm wake", wake_request, 1);
      @(posedge pclk) alarm_event <= 0;
      apb(1, PMGT_ADDR, 32'h18);
      apb(1, WAKE_CTRL_ADDR, 32'h18);
      settle();
      pulse_alarm();
      n = 0;
      while (wake_pin_oe !== 1'b1 && n < 50) @(posedge pclk) n++;
      chk("alarm on pin", wake_pin_oe, 1);
      apb(1, WAKE_CTRL_ADDR, 0);
      apb(1, PMGT_ADDR, 32'h13);
      ramp <= 4'hc;
      pg_wait(0);
      chk("regulator off", regulator_enable, 0);
      chk("analog por off", analog_por_enable, 0);
      chk("bandgap kept", bandgap_enable, 1);
      chk("isolated", rtc_isolate, 1);
      @(posedge pclk) wake_cmd <= 1;
      @(posedge pclk) wake_cmd <= 0;
      pg_wait(1);
      repeat (2) @(posedge pclk);
      chk("isolation off", rtc_isolate, 0);
      chk("system reset off", system_reset, 0);
      apb(0, PMGT_ADDR, 0);
      chk("pmgt retained", rd, 32'h11);
      ramp <= 4'h2;
      apb(1, PMGT_ADDR, 32'h14);
      pg_wait(0);
      chk("bandgap off", bandgap_enable, 0);
      pulse_alarm();
      pg_wait(1);
      chk("regulator back", regulator_enable, 1);
      end_of_test();
   end
endmodule // rtc_power_wakeup_control_bench
`default_nettype wire

// File: wake_partner.sv
`default_nettype none
// External wake source and supply monitor facing the wake pin.
module wake_partner #(
   parameter int HOLD = 20
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic regulator_enable,
   input wire logic wake_pin_oe,
   input wire logic wake_pin_out,
   input wire logic wake_cmd,
   input wire logic [3:0] ramp,
   output logic wake_pin_in,
   output logic supply_ok
);
   timeunit 1ns;
   timeprecision 100ps;
   int hold_cnt;
   int ramp_cnt;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) hold_cnt <= 0;
      else if (wake_cmd) hold_cnt <= HOLD;
      else if (hold_cnt > 0) hold_cnt <= hold_cnt - 1;
   end

   // Supply ramps slowly or promptly, as the bench asks, once enabled.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) ramp_cnt <= 0;
      else if (!regulator_enable) ramp_cnt <= 0;
      else if (ramp_cnt < 16) ramp_cnt <= ramp_cnt + 1;
   end
   assign supply_ok = regulator_enable && (ramp_cnt > int'(ramp));

   // The device pulling low wins; an idle source drives low, never X.
   assign wake_pin_in = wake_pin_oe ? wake_pin_out : (hold_cnt > 0);
endmodule // wake_partner
`default_nettype wire
